// *** src/txflag_defs.vh ***
// Register offsets, field positions, reset values and timing for tx flags
`ifndef TXFLAG_DEFS_VH
`define TXFLAG_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_TX_FIFO 4'h0
`define OFS_STATUS 4'h4
`define OFS_FIFO_CTRL 4'h8
`define OFS_FIFO_COUNT 4'hC
`define OFS_IRQ_STATUS 4'h0
`define OFS_IRQ_MASK 4'h4
`define SPACE_MAIN 1'b0
`define SPACE_IRQ 1'b1
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BIT_TX_END 6
`define BIT_FIFO_EMPTY 5
`define BIT_TRIG_HI 5
`define BIT_TRIG_LO 4
`define IRQ_TX_END 0
`define IRQ_FIFO_EMPTY 1
`define RST_TX_END 1'b1
`define RST_FIFO_EMPTY 1'b1
`define RST_TRIG 2'h0
`define RST_MASK 2'h0
// ----------------------------------------------------------------
// Trigger levels, FIFO and line timing
// ----------------------------------------------------------------
`define TRIG_SEL0 7'h08
`define TRIG_SEL1 7'h04
`define TRIG_SEL2 7'h02
`define TRIG_SEL3 7'h00
`define FIFO_DEPTH 64
`define FIFO_AW 6
`define BIT_CYCLES 16
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** src/tx_fifo_mem.v ***
// Transmit FIFO storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module tx_fifo_mem #(
  parameter DW = 8,
  parameter AW = 6
) (
  input wire aclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge aclk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// *** src/tx_shifter.v ***
// Transmit shift register: start bit, 8 data bits LSB first, stop bit
`timescale 1ns/1ps
`default_nettype none
`include "txflag_defs.vh"
module tx_shifter #(
  parameter BIT_CYCLES = `BIT_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire load,
  input wire [7:0] load_data,
  output reg busy_r,
  output reg done_r,
  output reg txd_r
);
  reg [9:0] frame_r;
  reg [3:0] bits_r;
  reg [15:0] tick_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      txd_r <= 1'b1;
      frame_r <= 10'h3FF;
      bits_r <= 4'h0;
      tick_r <= 16'h0000;
    end
    else
    begin
      done_r <= 1'b0;
      if (!busy_r)
      begin
        if (load)
        begin
          busy_r <= 1'b1;
          frame_r <= {1'b1, load_data, 1'b0};
          txd_r <= 1'b0;
          bits_r <= 4'h0;
          tick_r <= 16'h0000;
        end
      end
      else if (tick_r == BIT_CYCLES - 1)
      begin
        tick_r <= 16'h0000;
        if (bits_r == 4'h9)
        begin
          // Stop bit has fully left the line
          busy_r <= 1'b0;
          done_r <= 1'b1;
          txd_r <= 1'b1;
        end
        else
        begin
          bits_r <= bits_r + 4'h1;
          txd_r <= frame_r[bits_r + 4'h1];
        end
      end
      else
        tick_r <= tick_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** src/tx_flags_top.v ***
// Transmit FIFO, status flags, interrupt and AXI4-Lite register slave
//
// Contract
// RULE1: Transmit-end sets when the last bit has left and the FIFO is empty.
// RULE2: Transmit-end clears whenever software writes a byte to the FIFO.
// RULE3: FIFO-empty sets when a move to the shifter leaves count <= trigger.
// RULE4: FIFO-empty clears on a 0 write after reading 1, if count > trigger.
// RULE5: FIFO-empty is 1 after reset.
// RULE6: The FIFO holds 64 bytes and its count is readable in a register.
// RULE7: Bytes written to a full FIFO are discarded.
// RULE8: The trigger level comes from a two-bit select field in FIFO control.
// RULE9: The oldest byte moves to the idle shifter while the FIFO holds data.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "txflag_defs.vh"
module tx_flags_top #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW,
  parameter BIT_CYCLES = `BIT_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire txd,
  output reg irq_r
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [4:0] aw_addr_r;
  localparam [1:0] RST_SEL = `RST_TRIG;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;
  reg transmit_end_flag_r;
  reg tx_fifo_empty_flag_r;
  reg empty_seen_r;
  reg tx_trigger_select_hi_r;
  reg tx_trigger_select_lo_r;
  reg [1:0] irq_sts_r;
  reg [1:0] irq_mask_r;
  reg [AW:0] count_r;
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg fetch_r;
  reg [AW:0] trig;
  reg [31:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  wire do_wr;
  wire fifo_wr;
  wire push;
  wire pop;
  wire start_fetch;
  wire [AW:0] count_nxt;
  wire [7:0] mem_rdata;
  wire sh_busy;
  wire sh_done;
  wire end_set;
  wire empty_set;
  wire empty_clr;
  wire status_wr;
  wire [1:0] irq_ev;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign do_wr = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign fifo_wr = do_wr & (aw_addr_r[4] == `SPACE_MAIN) &
    (aw_addr_r[3:0] == `OFS_TX_FIFO) & w_strb_r[0];
  assign status_wr = do_wr & (aw_addr_r[4] == `SPACE_MAIN) &
    (aw_addr_r[3:0] == `OFS_STATUS) & w_strb_r[0];
  // A full FIFO silently drops the byte; the bus still answers OKAY
  assign push = fifo_wr & (count_r != DEPTH[AW:0]); // RULE7

  always @*
  begin
    wr_ok = 1'b0;
    if (aw_addr_r[4] == `SPACE_MAIN)
      wr_ok = (aw_addr_r[1:0] == 2'b00);
    else
      wr_ok = (aw_addr_r[3:0] == `OFS_IRQ_STATUS) ||
        (aw_addr_r[3:0] == `OFS_IRQ_MASK);
  end

  // ----------------------------------------------------------------
  // Trigger level
  // ----------------------------------------------------------------
  always @*
  begin
    case ({tx_trigger_select_hi_r, tx_trigger_select_lo_r}) // RULE8
      2'b00: trig = `TRIG_SEL0;
      2'b01: trig = `TRIG_SEL1;
      2'b10: trig = `TRIG_SEL2;
      2'b11: trig = `TRIG_SEL3;
      default: trig = `TRIG_SEL0;
    endcase
  end

  // ----------------------------------------------------------------
  // FIFO and transfer to the shifter
  // ----------------------------------------------------------------
  // One cycle fetch lets the registered memory read settle before load
  assign start_fetch = ~sh_busy & ~fetch_r & (count_r != {(AW+1){1'b0}});
  assign pop = fetch_r; // RULE9
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r <= {(AW+1){1'b0}};
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      fetch_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt; // RULE6
      fetch_r <= start_fetch;
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1}; // RULE9
    end
  end

  tx_fifo_mem #(
    .DW(8),
    .AW(AW)
  ) u_mem (
    .aclk(aclk),
    .wr_en(push),
    .wr_addr(wr_ptr_r),
    .wr_data(w_data_r[7:0]),
    .rd_addr(rd_ptr_r),
    .rd_data(mem_rdata)
  );

  tx_shifter #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(pop),
    .load_data(mem_rdata),
    .busy_r(sh_busy),
    .done_r(sh_done),
    .txd_r(txd)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A byte written in the same cycle means data is present, so no set
  assign end_set = sh_done & (count_r == {(AW+1){1'b0}}) & ~fetch_r &
    ~fifo_wr; // RULE1
  assign empty_set = pop & (count_nxt <= trig); // RULE3
  assign empty_clr = status_wr & ~w_data_r[`BIT_FIFO_EMPTY] &
    empty_seen_r & (count_r > trig); // RULE4
  assign irq_ev = {empty_set & ~tx_fifo_empty_flag_r,
    end_set & ~transmit_end_flag_r};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      transmit_end_flag_r <= `RST_TX_END;
      tx_fifo_empty_flag_r <= `RST_FIFO_EMPTY; // RULE5
      empty_seen_r <= 1'b0;
    end
    else
    begin
      if (end_set)
        transmit_end_flag_r <= 1'b1; // RULE1
      else if (fifo_wr)
        transmit_end_flag_r <= 1'b0; // RULE2
      // Hardware set wins over the software clear
      if (empty_set)
        tx_fifo_empty_flag_r <= 1'b1; // RULE3
      else if (empty_clr)
        tx_fifo_empty_flag_r <= 1'b0; // RULE4
      if (empty_clr || empty_set || status_wr)
        empty_seen_r <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[4] == `SPACE_MAIN &&
        s_axi_araddr[3:0] == `OFS_STATUS && tx_fifo_empty_flag_r)
        empty_seen_r <= 1'b1; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // Control, interrupt status and mask
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_trigger_select_hi_r <= RST_SEL[1];
      tx_trigger_select_lo_r <= RST_SEL[0];
      irq_sts_r <= 2'h0;
      irq_mask_r <= `RST_MASK;
      irq_r <= 1'b0;
    end
    else
    begin
      if (do_wr && w_strb_r[0] && aw_addr_r[4] == `SPACE_MAIN &&
        aw_addr_r[3:0] == `OFS_FIFO_CTRL)
      begin
        tx_trigger_select_hi_r <= w_data_r[`BIT_TRIG_HI]; // RULE8
        tx_trigger_select_lo_r <= w_data_r[`BIT_TRIG_LO]; // RULE8
      end
      if (do_wr && w_strb_r[0] && aw_addr_r[4] == `SPACE_IRQ &&
        aw_addr_r[3:0] == `OFS_IRQ_MASK)
        irq_mask_r <= w_data_r[1:0];
      // New events win over a write-one clear in the same cycle
      if (do_wr && w_strb_r[0] && aw_addr_r[4] == `SPACE_IRQ &&
        aw_addr_r[3:0] == `OFS_IRQ_STATUS)
        irq_sts_r <= (irq_sts_r & ~w_data_r[1:0]) | irq_ev;
      else
        irq_sts_r <= irq_sts_r | irq_ev;
      irq_r <= |(irq_sts_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[4] == `SPACE_MAIN)
    begin
      case (s_axi_araddr[3:0])
        `OFS_TX_FIFO: rd_val = 32'h00000000;
        `OFS_STATUS:
        begin
          rd_val[`BIT_TX_END] = transmit_end_flag_r;
          rd_val[`BIT_FIFO_EMPTY] = tx_fifo_empty_flag_r;
        end
        `OFS_FIFO_CTRL:
        begin
          rd_val[`BIT_TRIG_HI] = tx_trigger_select_hi_r;
          rd_val[`BIT_TRIG_LO] = tx_trigger_select_lo_r;
        end
        `OFS_FIFO_COUNT: rd_val[AW:0] = count_r; // RULE6
        default: rd_ok = 1'b0;
      endcase
    end
    else
    begin
      case (s_axi_araddr[3:0])
        `OFS_IRQ_STATUS: rd_val[1:0] = irq_sts_r;
        `OFS_IRQ_MASK: rd_val[1:0] = irq_mask_r;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_val : 32'h00000000;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tx_flags_props.sv ***
// Port assertions for the transmit flag block
`timescale 1ns/1ps
`default_nettype none
module tx_flags_props #(
  parameter BIT_CYCLES = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire txd,
  input wire irq_r
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no b");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no r");
  a_wr_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overlap");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[4:3] == 2'h3 |=> s_axi_rresp == 2'h2 &&
    s_axi_rdata == 32'h0) else $error("unmapped read");
  // Bench runs with a long bit time, so eight low cycles must follow
  a_start_bit: assert property ($fell(txd) |=> !txd [*8])
    else $error("short start bit");
endmodule
bind tx_flags_top tx_flags_props #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .txd(txd),
  .irq_r(irq_r)
);
`default_nettype wire

// *** tb/line_receiver.sv ***
// Serial receiver model on the transmit line
`timescale 1ns/1ps
`default_nettype none
module line_receiver #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic aclk,
  input wire logic rxd,
  output logic [7:0] data_r,
  output int rx_count,
  output logic [31:0] sum,
  output logic frame_err_r
);
  // ----
  // Mid-bit sampling, 8N1
  // ----
  initial
  begin
    rx_count = 0;
    sum = 32'h00000000;
    data_r = 8'h00;
    frame_err_r = 1'b0;
    forever
    begin
      @(negedge rxd);
      repeat (BIT_CYCLES / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge aclk);
        data_r[i] = rxd;
      end
      repeat (BIT_CYCLES) @(posedge aclk);
      if (!rxd)
        frame_err_r = 1'b1;
      sum = sum + {24'h000000, data_r};
      rx_count++;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the transmit flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
      n_errors++; \
    end \
  end
module tb_top;
  // ----
  // Signals and instances
  // ----
  localparam int BC = 64;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic [4:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, txd, irq_r, rx_err;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] rx_byte;
  int rx_n;
  logic [31:0] rx_sum;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] v;
  logic [1:0] resp;
  tx_flags_top #(.BIT_CYCLES(BC)) dut_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .txd(txd),
    .irq_r(irq_r)
  );
  line_receiver #(.BIT_CYCLES(BC)) rx_u (.aclk(aclk), .rxd(txd),
    .data_r(rx_byte), .rx_count(rx_n), .sum(rx_sum), .frame_err_r(rx_err));
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  task automatic stop_test();
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task automatic hang(input int n, input int lim);
    begin
      if (n > lim)
      begin
        $display("[ERR] wait exp done got timeout");
        n_errors++;
        stop_test();
      end
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
          s_axi_bready <= 1'b1;
        hang(n, 50);
      end
      while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [4:0] a);
    int n;
    begin
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
        @(posedge aclk);
        n++;
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
          s_axi_rready <= 1'b1;
        hang(n, 50);
      end
      while (!(s_axi_rvalid && s_axi_rready));
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task automatic wait_rx(input int k);
    int n;
    begin
      n = 0;
      while (rx_n < k)
      begin
        @(posedge aclk);
        n++;
        hang(n, 3000);
      end
    end
  endtask
  // Count moves once per frame, so polling sees every value
  task automatic poll(input logic [6:0] k);
    int n;
    begin
      n = 0;
      rd(5'h0C);
      while (v[6:0] > k)
      begin
        rd(5'h0C);
        n++;
        hang(n, 20000);
      end
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    begin
      rd(5'h04);
      `CHK("end", 1'b1, v[6])
      `CHK("empty", 1'b1, v[5])
      rd(5'h0C);
      `CHK("count", 7'h00, v[6:0])
      rd(5'h08);
      `CHK("trig", 2'h0, v[5:4])
      rd(5'h18);
      `CHK("rresp", 2'h2, resp)
      wr(5'h1C, 32'h0);
      `CHK("bresp", 2'h2, resp)
      $display("t_reset done");
    end
  endtask
  task automatic t_send();
    begin
      wr(5'h00, 32'hA5);
      rd(5'h04);
      `CHK("end", 1'b0, v[6])
      wait_rx(1);
      `CHK("rx byte", 8'hA5, rx_byte)
      repeat (BC) @(posedge aclk);
      rd(5'h04);
      `CHK("end", 1'b1, v[6])
      rd(5'h10);
      `CHK("irq st", 1'b1, v[0])
      `CHK("irq", 1'b0, irq_r)
      wr(5'h14, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("irq", 1'b1, irq_r)
      wr(5'h10, 32'h1);
      repeat (2) @(posedge aclk);
      `CHK("irq", 1'b0, irq_r)
      $display("t_send done");
    end
  endtask
  task automatic t_fill();
    begin
      rd(5'h04);
      wr(5'h04, 32'h0);
      rd(5'h04);
      `CHK("empty", 1'b1, v[5])
      for (int i = 0; i < 66; i++)
        wr(5'h00, 32'(i));
      rd(5'h0C);
      `CHK("count", 7'h40, v[6:0])
      wr(5'h04, 32'h0);
      rd(5'h04);
      `CHK("empty", 1'b1, v[5])
      wr(5'h04, 32'h0);
      rd(5'h04);
      `CHK("empty", 1'b0, v[5])
      $display("t_fill done");
    end
  endtask
  task automatic t_level(input logic [1:0] s, input logic [6:0] l);
    begin
      wr(5'h08, {26'h0, s, 4'h0});
      rd(5'h04);
      wr(5'h04, 32'h0);
      poll(l + 7'h01);
      rd(5'h04);
      `CHK("empty", 1'b0, v[5])
      poll(l);
      `CHK("count", l, v[6:0])
      rd(5'h04);
      `CHK("empty", 1'b1, v[5])
      $display("t_level %0d done", l);
    end
  endtask
  // Manual reset mid-run with the flag cleared and bytes still queued
  task automatic t_rerst();
    begin
      wr(5'h00, 32'h11);
      wr(5'h00, 32'h22);
      rd(5'h04);
      `CHK("end", 1'b0, v[6])
      wr(5'h04, 32'h0);
      rd(5'h04);
      `CHK("empty", 1'b0, v[5])
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(5'h04);
      `CHK("end", 1'b1, v[6])
      `CHK("empty", 1'b1, v[5])
      rd(5'h0C);
      `CHK("count", 7'h00, v[6:0])
      `CHK("txd", 1'b1, txd)
      $display("t_rerst done");
    end
  endtask
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_send();
    t_fill();
    t_level(2'h0, 7'h08);
    t_level(2'h1, 7'h04);
    t_level(2'h2, 7'h02);
    t_level(2'h3, 7'h00);
    wait_rx(66);
    `CHK("rx sum", 32'h000008C5, rx_sum)
    `CHK("rx last", 8'h40, rx_byte)
    `CHK("frame", 1'b0, rx_err)
    t_rerst();
    stop_test();
  end
endmodule
`default_nettype wire
